// ---- rtl/eid_decoder.sv ----
// Functional notes
// - access bit zero, f<=5Fh: indexed addressing
// - extension on when unprogrammed; config bit decides
// - decode eight extra literal instructions
// - pointer add/sub: one cycle, no flags
// - select 11 targets stack pointer, returns
// - add-and-return: two cycles, no flags
// - sub-and-return: two cycles, no flags
// - call via working reg: fixed pattern, two cycles
// - move stack to file: two words, cycles
// - move stack to stack: two words, cycles
// - push literal at stack pointer, then decrement
// - call pushes PC+2, loads PC from latches and working reg
// - return variants step pointer and pop PC at the same edge
module eid_decoder
  import eid_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              cfg_programmed,
  input  wire logic              extension_enable_cfg,
  input  wire logic              insn_valid,
  input  wire logic [15:0]       insn_word,
  input  wire logic              byte_op,
  input  wire logic [7:0]        working_register,
  input  wire logic [7:0]        pc_high_latch,
  input  wire logic [4:0]        pc_upper_latch,
  input  wire logic [PC_W-1:0]   pc_current,
  input  wire logic [PC_W-1:0]   return_stack_top,
  input  wire logic [3:0]        bank_select_reg,
  input  wire logic              ptr_wr,
  input  wire logic [1:0]        ptr_wsel,
  input  wire logic [PTR_W-1:0]  ptr_wdata,
  input  wire logic [7:0]        mem_rdata,
  output logic                   ext_active,
  output logic      [PTR_W-1:0]  pointer_register0,
  output logic      [PTR_W-1:0]  pointer_register1,
  output logic      [PTR_W-1:0]  software_stack_pointer,
  output logic                   pc_load,
  output logic      [PC_W-1:0]   pc_value,
  output logic                   ret_push,
  output logic      [PC_W-1:0]   ret_push_value,
  output logic                   ret_pop,
  output logic                   mem_rd,
  output logic      [ADDR_W-1:0] mem_raddr,
  output logic                   mem_wr,
  output logic      [ADDR_W-1:0] mem_waddr,
  output logic      [7:0]        mem_wdata,
  output logic                   fetch_second,
  output logic                   exec_hold,
  output logic                   flag_write_inhibit,
  output logic      [ADDR_W-1:0] byte_addr,
  output logic                   byte_indexed
);

  logic [Q_W-1:0]   q;
  logic             cfg_seen;
  eid_op_t          op;
  eid_op_t          next_op;
  eid_state_t       state;
  logic [15:0]      word1;
  logic [15:0]      word2;
  logic [7:0]       src_data;
  logic [PTR_W-1:0] ptr_q [3];
  logic             in_first;
  logic             is_move;
  logic             two_cycle;
  logic             rd_go;
  logic             wr1_go;
  logic             wr2_go;
  logic             take_word;

  eid_qphase u_qphase (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .q       (q)
  );

  // ---------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_seen   <= 1'h0;
      ext_active <= RST_EXT_EN;
    end else if (!cfg_seen) begin
      cfg_seen   <= 1'h1;
      ext_active <= cfg_programmed ? extension_enable_cfg : RST_EXT_EN;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    next_op = OP_NONE;
    if (ext_active) begin
      if (insn_word == OPC_CALL_WORK) begin
        next_op = OP_CALL_WORK;
      end else if (insn_word[15:8] == OPC_ADD_PTR) begin
        next_op = (insn_word[SEL_HI:SEL_LO] == SEL_STACK) ? OP_ADD_RET : OP_ADD_PTR;
      end else if (insn_word[15:8] == OPC_SUB_PTR) begin
        next_op = (insn_word[SEL_HI:SEL_LO] == SEL_STACK) ? OP_SUB_RET : OP_SUB_PTR;
      end else if (insn_word[15:8] == OPC_PUSH) begin
        next_op = OP_PUSH;
      end else if (insn_word[15:8] == OPC_MOVE) begin
        next_op = insn_word[MOVE_KIND_BIT] ? OP_MOVE_STACK : OP_MOVE_TO_FILE;
      end
    end
  end

  assign in_first  = (state == ST_FIRST);
  assign is_move   = (op == OP_MOVE_TO_FILE) || (op == OP_MOVE_STACK);
  assign two_cycle = is_move || (op == OP_CALL_WORK) || (op == OP_ADD_RET) || (op == OP_SUB_RET);
  assign take_word = (q == Q_FIRST) && insn_valid;
  assign rd_go     = in_first && (q == Q_READ) && is_move;
  assign wr1_go    = in_first && (q == Q_PROC) && (op != OP_NONE);
  assign wr2_go    = !in_first && (q == Q_PROC) && is_move;

  // ---------------------------------------------------------------
  // instruction cycle sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_FIRST;
      op        <= OP_NONE;
      exec_hold <= 1'h0;
    end else if (in_first && (q == Q_FIRST)) begin
      op <= insn_valid ? next_op : OP_NONE;
    end else if ((q == Q_WRITE) && in_first && two_cycle) begin
      state     <= ST_SECOND;
      exec_hold <= 1'h1;
    end else if ((q == Q_WRITE) && !in_first) begin
      state     <= ST_FIRST;
      op        <= OP_NONE;
      exec_hold <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word1 <= 16'h0000;
      word2 <= 16'h0000;
    end else if (take_word && in_first) begin
      word1 <= insn_word;
    end else if (take_word && is_move) begin
      word2 <= insn_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_write_inhibit <= 1'h0;
    end else begin
      flag_write_inhibit <= (op != OP_NONE);
    end
  end

  // ---------------------------------------------------------------
  // pointer registers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    logic sel_hit;
    logic sp_hit;
    assign sel_hit = ((op == OP_ADD_PTR) || (op == OP_SUB_PTR)) && (word1[SEL_HI:SEL_LO] == 2'(i));
    assign sp_hit  = (i == SP_IDX) && ((op == OP_ADD_RET) || (op == OP_SUB_RET) || (op == OP_PUSH));
    eid_ptr_unit #(
      .W (PTR_W)
    ) u_ptr (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .load       (ptr_wr && (ptr_wsel == 2'(i))),
      .load_value (ptr_wdata),
      .step_en    (wr1_go && (sel_hit || sp_hit)),
      .step_down  ((op == OP_SUB_PTR) || (op == OP_SUB_RET) || (op == OP_PUSH)),
      .step       ((op == OP_PUSH) ? PUSH_STEP : word1[5:0]),
      .value      (ptr_q[i])
    );
  end

  assign pointer_register0      = ptr_q[0];
  assign pointer_register1      = ptr_q[1];
  assign software_stack_pointer = ptr_q[SP_IDX];

  // ---------------------------------------------------------------
  // program counter and return stack
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load        <= 1'h0;
      pc_value       <= '0;
      ret_push       <= 1'h0;
      ret_push_value <= '0;
      ret_pop        <= 1'h0;
    end else begin
      pc_load  <= 1'h0;
      ret_push <= 1'h0;
      ret_pop  <= 1'h0;
      if (wr1_go && (op == OP_CALL_WORK)) begin
        ret_push       <= 1'h1;
        ret_push_value <= pc_current + RET_OFFSET;
        pc_load        <= 1'h1;
        pc_value       <= {pc_upper_latch, pc_high_latch, working_register};
      end else if (wr1_go && ((op == OP_ADD_RET) || (op == OP_SUB_RET))) begin
        pc_load  <= 1'h1;
        pc_value <= return_stack_top;
        ret_pop  <= 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // data memory moves and push
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd       <= 1'h0;
      mem_raddr    <= '0;
      fetch_second <= 1'h0;
      src_data     <= 8'h00;
    end else begin
      mem_rd       <= rd_go;
      fetch_second <= in_first && (q == Q_PROC) && is_move;
      if (rd_go) begin
        mem_raddr <= ptr_q[SP_IDX] + ADDR_W'(word1[6:0]);
      end
      if (in_first && (q == Q_PROC) && is_move) begin
        src_data <= mem_rdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr    <= 1'h0;
      mem_waddr <= '0;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= 1'h0;
      if (wr1_go && (op == OP_PUSH)) begin
        mem_wr    <= 1'h1;
        mem_waddr <= ptr_q[SP_IDX];
        mem_wdata <= word1[7:0];
      end else if (wr2_go) begin
        mem_wr    <= 1'h1;
        mem_wdata <= src_data;
        mem_waddr <= (op == OP_MOVE_STACK) ? ptr_q[SP_IDX] + ADDR_W'(word2[6:0]) : word2[11:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // byte instruction addressing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_addr    <= '0;
      byte_indexed <= 1'h0;
    end else if (take_word && in_first && byte_op) begin
      byte_indexed <= 1'h0;
      if (insn_word[ACCESS_BIT]) begin
        byte_addr <= {bank_select_reg, insn_word[7:0]};
      end else if (ext_active && (insn_word[7:0] <= INDEX_LIMIT)) begin
        byte_indexed <= 1'h1;
        byte_addr    <= ptr_q[SP_IDX] + ADDR_W'(insn_word[7:0]);
      end else if (insn_word[7:0] <= INDEX_LIMIT) begin
        byte_addr <= {4'h0, insn_word[7:0]};
      end else begin
        byte_addr <= ACCESS_HIGH_BASE | {4'h0, insn_word[7:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic dec_go;
  assign dec_go = in_first && take_word;

  sequence s_two_cycle_tail;
    exec_hold [*4] ##1 !exec_hold;
  endsequence

  sequence s_ret_go;
    wr1_go && ((op == OP_ADD_RET) || (op == OP_SUB_RET));
  endsequence

  a_index_byte_addr: assert property (
    (dec_go && byte_op && !insn_word[ACCESS_BIT] && ext_active && insn_word[7:0] <= INDEX_LIMIT)
      |=> byte_indexed && (byte_addr == $past(ptr_q[SP_IDX]) + ADDR_W'($past(insn_word[7:0]))))
    else $error("indexed byte address wrong");
  a_ext_default_on: assert property (
    (!cfg_seen && !cfg_programmed) |=> ext_active)
    else $error("extension not on when unprogrammed");
  a_ext_gate_off: assert property (
    (dec_go && !ext_active) |=> (op == OP_NONE) ##2 !flag_write_inhibit)
    else $error("extended opcode decoded while disabled");
  a_ret_sel_decode: assert property (
    (dec_go && ext_active && insn_word[15:8] == OPC_ADD_PTR && insn_word[SEL_HI:SEL_LO] == SEL_STACK)
      |=> (op == OP_ADD_RET))
    else $error("stack select not decoded as return");
  a_ptr_add_once: assert property (
    (wr1_go && op == OP_ADD_PTR && word1[SEL_HI:SEL_LO] == 2'h1)
      |=> (ptr_q[1] == $past(ptr_q[1]) + PTR_W'($past(word1[5:0]))) && !exec_hold ##1 !exec_hold)
    else $error("pointer add wrong");
  a_ret_two_cycles: assert property (
    s_ret_go |=> pc_load && ret_pop && (pc_value == $past(return_stack_top)) ##1 s_two_cycle_tail)
    else $error("return variant sequence wrong");
  a_call_push_pc: assert property (
    (wr1_go && op == OP_CALL_WORK)
      |=> ret_push && (ret_push_value == $past(pc_current) + RET_OFFSET)
          && (pc_value[7:0] == $past(working_register)) ##1 s_two_cycle_tail)
    else $error("call via working register wrong");
  a_call_decode: assert property (
    (dec_go && ext_active && insn_word == OPC_CALL_WORK) |=> (op == OP_CALL_WORK) ##[1:3] pc_load)
    else $error("call pattern not decoded");
  a_push_literal: assert property (
    (wr1_go && op == OP_PUSH)
      |=> mem_wr && (mem_waddr == $past(ptr_q[SP_IDX])) && (ptr_q[SP_IDX] == $past(ptr_q[SP_IDX]) - PTR_W'(1))
          && !exec_hold)
    else $error("push literal wrong");

  a_move_file_flow: assert property (
    (rd_go && op == OP_MOVE_TO_FILE) |=> mem_rd ##1 fetch_second ##4 mem_wr ##1 !exec_hold)
    else $error("move to file sequence wrong");

  a_move_stack_flow: assert property (
    (rd_go && op == OP_MOVE_STACK) |=> mem_rd ##1 fetch_second && !mem_wr ##4 mem_wr)
    else $error("move stack to stack sequence wrong");

endmodule

// ---- rtl/eid_pkg.sv ----
package eid_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PTR_W  = 12;
  localparam int PC_W   = 21;
  localparam int ADDR_W = 12;
  localparam int Q_W    = 2;

  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam logic [7:0]  OPC_ADD_PTR   = 8'hE8;
  localparam logic [7:0]  OPC_SUB_PTR   = 8'hE9;
  localparam logic [7:0]  OPC_PUSH      = 8'hEA;
  localparam logic [7:0]  OPC_MOVE      = 8'hEB;
  localparam logic [15:0] OPC_CALL_WORK = 16'h0014;
  localparam logic [1:0]  SEL_STACK     = 2'h3;
  localparam int          SEL_HI        = 7;
  localparam int          SEL_LO        = 6;
  localparam int          MOVE_KIND_BIT = 7;
  localparam int          ACCESS_BIT    = 8;

  // ---------------------------------------------------------------
  // addressing constants
  // ---------------------------------------------------------------
  localparam logic [7:0]        INDEX_LIMIT      = 8'h5F;
  localparam logic [ADDR_W-1:0] ACCESS_HIGH_BASE = 12'hF00;
  localparam logic [PC_W-1:0]   RET_OFFSET       = 21'h000002;
  localparam logic [5:0]        PUSH_STEP        = 6'h01;
  localparam int                SP_IDX           = 2;

  // ---------------------------------------------------------------
  // phases of one instruction cycle
  // ---------------------------------------------------------------
  localparam logic [Q_W-1:0] Q_FIRST = 2'h0;
  localparam logic [Q_W-1:0] Q_READ  = 2'h1;
  localparam logic [Q_W-1:0] Q_PROC  = 2'h2;
  localparam logic [Q_W-1:0] Q_WRITE = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic             RST_EXT_EN = 1'h1;
  localparam logic [PTR_W-1:0] PTR_RST    = 12'h000;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD_PTR, OP_SUB_PTR, OP_ADD_RET, OP_SUB_RET,
    OP_CALL_WORK, OP_MOVE_TO_FILE, OP_MOVE_STACK, OP_PUSH
  } eid_op_t;

  typedef enum logic {ST_FIRST, ST_SECOND} eid_state_t;

endpackage

// ---- rtl/eid_qphase.sv ----
module eid_qphase
  import eid_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  output logic      [Q_W-1:0] q
);

  // ---------------------------------------------------------------
  // four phases per instruction cycle
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= Q_FIRST;
    end else begin
      q <= q + 2'h1;
    end
  end

endmodule

// ---- rtl/eid_ptr_unit.sv ----
module eid_ptr_unit
  import eid_pkg::*;
#(
  parameter int W = PTR_W
)
(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         step_en,
  input  wire logic         step_down,
  input  wire logic [5:0]   step,
  output logic      [W-1:0] value
);

  // ---------------------------------------------------------------
  // pointer register, extended step wins over core load
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= W'(PTR_RST);
    end else if (step_en) begin
      value <= step_down ? value - W'(step) : value + W'(step);
    end else if (load) begin
      value <= load_value;
    end
  end

endmodule

// ---- bench/eid_tb.sv ----
module tb
  import eid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic              ref_clk;
  logic              rst_n;
  logic              cfg_programmed;
  logic              extension_enable_cfg;
  logic              insn_valid;
  logic [15:0]       insn_word;
  logic              byte_op;
  logic [7:0]        working_register;
  logic [7:0]        pc_high_latch;
  logic [4:0]        pc_upper_latch;
  logic [PC_W-1:0]   pc_current;
  logic [PC_W-1:0]   return_stack_top;
  logic [3:0]        bank_select_reg;
  logic              ptr_wr;
  logic [1:0]        ptr_wsel;
  logic [PTR_W-1:0]  ptr_wdata;
  logic [7:0]        mem_rdata;
  logic              ext_active;
  logic [PTR_W-1:0]  pointer_register0;
  logic [PTR_W-1:0]  pointer_register1;
  logic [PTR_W-1:0]  software_stack_pointer;
  logic              pc_load;
  logic [PC_W-1:0]   pc_value;
  logic              ret_push;
  logic [PC_W-1:0]   ret_push_value;
  logic              ret_pop;
  logic              mem_rd;
  logic [ADDR_W-1:0] mem_raddr;
  logic              mem_wr;
  logic [ADDR_W-1:0] mem_waddr;
  logic [7:0]        mem_wdata;
  logic              fetch_second;
  logic              exec_hold;
  logic              flag_write_inhibit;
  logic [ADDR_W-1:0] byte_addr;
  logic              byte_indexed;
  logic [1:0]        ph;
  int                error_cnt;
  int                tests_run;

  eid_decoder eid_decoder_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_programmed(cfg_programmed),
    .extension_enable_cfg(extension_enable_cfg), .insn_valid(insn_valid), .insn_word(insn_word),
    .byte_op(byte_op), .working_register(working_register), .pc_high_latch(pc_high_latch),
    .pc_upper_latch(pc_upper_latch), .pc_current(pc_current), .return_stack_top(return_stack_top),
    .bank_select_reg(bank_select_reg), .ptr_wr(ptr_wr), .ptr_wsel(ptr_wsel), .ptr_wdata(ptr_wdata),
    .mem_rdata(mem_rdata), .ext_active(ext_active), .pointer_register0(pointer_register0),
    .pointer_register1(pointer_register1), .software_stack_pointer(software_stack_pointer),
    .pc_load(pc_load), .pc_value(pc_value), .ret_push(ret_push), .ret_push_value(ret_push_value),
    .ret_pop(ret_pop), .mem_rd(mem_rd), .mem_raddr(mem_raddr), .mem_wr(mem_wr), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .fetch_second(fetch_second), .exec_hold(exec_hold),
    .flag_write_inhibit(flag_write_inhibit), .byte_addr(byte_addr), .byte_indexed(byte_indexed)
  );

  // ---------------------------------------------------------------
  // clock, data memory, phase mirror
  // ---------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  // memory byte is address low byte xor a5
  assign mem_rdata = mem_raddr[7:0] ^ 8'hA5;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ph <= 2'h0;
    else ph <= ph + 2'h1;
  end

  // ---------------------------------------------------------------
  // shared tasks; every task but chk and stop_test returns just after a falling edge
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset(input logic prog, input logic en);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    cfg_programmed <= prog;
    extension_enable_cfg <= en;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic set_ptr(input logic [1:0] sel, input logic [PTR_W-1:0] val);
    @(posedge ref_clk);
    ptr_wr <= 1'b1;
    ptr_wsel <= sel;
    ptr_wdata <= val;
    @(posedge ref_clk);
    ptr_wr <= 1'b0;
    @(negedge ref_clk);
  endtask

  // word taken at the edge ending phase 0; returns in phase 1
  task automatic issue(input logic [15:0] w, input logic bop);
    int i;
    i = 0;
    while (ph !== 2'h3 && i < 8) begin
      @(negedge ref_clk);
      i++;
    end
    if (ph !== 2'h3) begin
      error_cnt++;
      $display("mismatch at %0t: phase wait ran out", $time);
      stop_test();
    end else begin
      @(posedge ref_clk);
      insn_valid <= 1'h1;
      insn_word <= w;
      byte_op <= bop;
      @(posedge ref_clk);
      insn_valid <= 1'h0;
      byte_op <= 1'h0;
      @(negedge ref_clk);
    end
  endtask

  // issue and move on to phase 3, where effects show
  task automatic exec(input logic [15:0] w);
    issue(w, 1'b0);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  function automatic logic [PTR_W-1:0] ptr_of(input logic [1:0] s);
    case (s)
      2'h0: return pointer_register0;
      2'h1: return pointer_register1;
      default: return software_stack_pointer;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_ptr();
    for (int s = 0; s < 3; s++) begin
      set_ptr(2'(s), 12'h3FF);
      exec({OPC_ADD_PTR, 2'(s), 6'h23});
      chk(21'(ptr_of(2'(s))), 21'h422, "add to pointer");
      chk(21'(flag_write_inhibit), 21'h1, "flags held on add");
      chk(21'(pc_load), 21'h0, "add must not return");
      exec({OPC_SUB_PTR, 2'(s), 6'h3F});
      chk(21'(ptr_of(2'(s))), 21'h3E3, "sub from pointer");
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(21'(exec_hold), 21'h0, "one cycle only");
    end
  endtask

  task automatic t_ret();
    set_ptr(2'h0, 12'h010);
    set_ptr(2'h2, 12'h3FF);
    @(posedge ref_clk);
    return_stack_top <= 21'h1ABCD;
    for (int i = 0; i < 2; i++) begin
      exec({(i == 1) ? OPC_SUB_PTR : OPC_ADD_PTR, SEL_STACK, 6'h23});
      chk(21'(software_stack_pointer), (i == 1) ? 21'h3FF : 21'h422, "stack step");
      chk(21'(pc_load), 21'h1, "return load");
      chk(pc_value, 21'h1ABCD, "return target");
      chk(21'(ret_pop), 21'h1, "return pop");
      chk(21'(flag_write_inhibit), 21'h1, "flags held on return");
      exec({OPC_ADD_PTR, 2'h0, 6'h05});
      chk(21'(exec_hold), 21'h1, "second cycle");
      chk(21'(pointer_register0), 21'h010, "word in second cycle ignored");
      chk(21'(pc_load), 21'h0, "load is one pulse");
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(21'(exec_hold), 21'h0, "two cycles only");
    end
  endtask

  task automatic t_call();
    @(posedge ref_clk);
    working_register <= 8'h3C;
    pc_high_latch <= 8'h5A;
    pc_upper_latch <= 5'h1B;
    pc_current <= 21'h012345;
    exec(16'h0015);
    chk(21'(pc_load | ret_push), 21'h0, "near pattern not a call");
    exec(OPC_CALL_WORK);
    chk(21'(ret_push), 21'h1, "call push");
    chk(ret_push_value, 21'h012347, "return address");
    chk(21'(pc_load), 21'h1, "call load");
    chk(pc_value, 21'h1B5A3C, "call target");
    chk(21'(flag_write_inhibit), 21'h1, "flags held on call");
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(21'(exec_hold), 21'h1, "call second cycle");
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(21'(exec_hold), 21'h0, "call two cycles");
  endtask

  task automatic t_push();
    set_ptr(2'h2, 12'h080);
    for (int i = 0; i < 2; i++) begin
      exec({OPC_PUSH, (i == 1) ? 8'h3C : 8'hC3});
      chk(21'(mem_wr), 21'h1, "push write");
      chk(21'(mem_waddr), (i == 1) ? 21'h07F : 21'h080, "push address");
      chk(21'(mem_wdata), (i == 1) ? 21'h3C : 21'hC3, "push data");
      chk(21'(software_stack_pointer), (i == 1) ? 21'h07E : 21'h07F, "push decrement");
    end
  endtask

  task automatic t_move(input logic kind);
    set_ptr(2'h2, 12'h100);
    issue({OPC_MOVE, kind, 7'h05}, 1'b0);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(21'(mem_rd), 21'h1, "move read");
    chk(21'(mem_raddr), 21'h105, "move source");
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(21'(fetch_second), 21'h1, "second word request");
    exec(kind ? 16'hFF8A : 16'hF234);
    chk(21'(mem_wr), 21'h1, "move write");
    chk(21'(mem_waddr), kind ? 21'h10A : 21'h234, "move destination");
    chk(21'(mem_wdata), 21'hA0, "move data");
    chk(21'(exec_hold), 21'h1, "move second cycle");
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(21'(exec_hold), 21'h0, "move two cycles");
  endtask

  task automatic t_byte(input logic en);
    @(posedge ref_clk);
    bank_select_reg <= 4'h7;
    set_ptr(2'h2, 12'h200);
    issue(16'h1A5F, 1'b1);
    chk(21'(byte_addr), en ? 21'h25F : 21'h05F, "limit offset");
    chk(21'(byte_indexed), 21'(en), "limit indexed");
    issue(16'h1A60, 1'b1);
    chk(21'(byte_addr), 21'hF60, "above limit");
    chk(21'(byte_indexed), 21'h0, "above limit direct");
    issue(16'h1B20, 1'b1);
    chk(21'(byte_addr), 21'h720, "banked");
    chk(21'(byte_indexed), 21'h0, "banked direct");
  endtask

  task automatic t_disabled();
    do_reset(1'b1, 1'b0);
    chk(21'(ext_active), 21'h0, "cleared bit disables");
    set_ptr(2'h1, 12'h100);
    exec({OPC_ADD_PTR, 2'h1, 6'h23});
    chk(21'(pointer_register1), 21'h100, "no add when off");
    chk(21'(flag_write_inhibit), 21'h0, "no inhibit when off");
    exec(OPC_CALL_WORK);
    chk(21'(pc_load | ret_push), 21'h0, "no call when off");
    exec({OPC_PUSH, 8'h55});
    chk(21'(mem_wr), 21'h0, "no push when off");
    t_byte(1'b0);
    do_reset(1'b0, 1'b0);
    chk(21'(ext_active), 21'h1, "unprogrammed enables");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    cfg_programmed = 1'b1;
    extension_enable_cfg = 1'b1;
    insn_valid = 1'b0;
    insn_word = 16'h0000;
    byte_op = 1'b0;
    working_register = 8'h00;
    pc_high_latch = 8'h00;
    pc_upper_latch = 5'h00;
    pc_current = 21'h000000;
    return_stack_top = 21'h000000;
    bank_select_reg = 4'h0;
    ptr_wr = 1'b0;
    ptr_wsel = 2'h0;
    ptr_wdata = 12'h000;
    error_cnt = 0;
    tests_run = 0;
    do_reset(1'b1, 1'b1);
    chk(21'(ext_active), 21'h1, "set bit enables");
    chk(21'(pointer_register0 | pointer_register1 | software_stack_pointer), 21'h0, "pointer reset");
    t_ptr();
    t_ret();
    t_call();
    t_push();
    t_move(1'b0);
    t_move(1'b1);
    t_byte(1'b1);
    t_disabled();
    stop_test();
  end

endmodule
